// ==== logic/sbm_pkg.sv ====
package sbm_pkg;

	// ==========================================================
	// address layout
	// ==========================================================
	localparam int ADDR_W = 8; // bank bit plus seven-bit offset
	localparam int BANK_BIT = 7; // direct bank select seen on the address
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_PCL = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] OFF_HOLDING = 7'h0a;
	localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0b;
	localparam logic [6:0] OFF_PERIPHERAL_IRQ_FLAGS = 7'h0c;
	localparam logic [6:0] SFR_SPAN = 7'h20; // offsets below this are special registers

	// ==========================================================
	// core status layout and reset values
	// ==========================================================
	localparam int STATUS_TO_BIT = 4;
	localparam int STATUS_PD_BIT = 3;
	localparam logic [7:0] STATUS_POR = 8'h18;
	localparam logic [7:0] STATUS_WR_MASK = 8'he7; // timeout and power-down are read only
	localparam logic [7:0] STATUS_KEEP = 8'h07; // arithmetic flags survive other resets

	// ==========================================================
	// interrupt control and flags
	// ==========================================================
	localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_KEEP = 8'h01; // port change flag survives other resets
	localparam int INTERRUPT_CONTROL_FLAGS = 3; // low bits set by hardware
	localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_RST = 8'h00;
	localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_IMPL = 8'hcf; // bits 5:4 are unimplemented

	// ==========================================================
	// program counter
	// ==========================================================
	localparam int PC_W = 13;
	localparam int HOLD_W = 5;
	localparam int JUMP_W = 11;

	// ==========================================================
	// plain storage registers: offset, mask, power-on value,
	// other-reset value, bits kept on other resets, pin readback
	// ==========================================================
	localparam int NREG = 18;
	localparam int IDX_POINTER = 1;
	localparam int IDX_HOLDING = 2;
	localparam logic [6:0] REG_OFF [NREG] = '{7'h01, 7'h04, 7'h0a, 7'h0e, 7'h0f, 7'h10,
		7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09};
	localparam logic [7:0] REG_MASK [NREG] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h3f,
		8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07};
	localparam logic [7:0] REG_POR [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] REG_OTHER [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] REG_KEEP [NREG] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h3f,
		8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07};
	localparam logic REG_PIN [NREG] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam int IDX_PORT0 = 13;
	localparam int NPORT = 5;

endpackage

// ==== logic/sbm_reg.sv ====
`timescale 1ns/100ps
module sbm_reg
	import sbm_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff,
	parameter logic [7:0] POR_VAL = 8'h00,
	parameter logic [7:0] OTHER_VAL = 8'h00,
	parameter logic [7:0] KEEP = 8'h00
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rst_por,
	// write side
	input wire logic we,
	input wire logic [7:0] wdata,
	// stored value
	output logic [7:0] q
);

	logic [7:0] next_q; // value for the coming edge

	// ==========================================================
	// next value: unimplemented bits stay zero
	// ==========================================================
	always_comb begin
		next_q = q;
		if (sys_rst) begin
			// power-up resets load fully, others keep the unchanged bits
			if (rst_por) begin
				next_q = POR_VAL & MASK;
			end else begin
				next_q = ((q & KEEP) | (OTHER_VAL & ~KEEP)) & MASK;
			end
		end else if (we) begin
			next_q = wdata & MASK;
		end
	end

	// register only
	always_ff @(posedge clk) begin
		q <= next_q;
	end

endmodule

// ==== logic/sbm_pc.sv ====
`timescale 1ns/100ps
module sbm_pc
	import sbm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// counter controls
	input wire logic pc_step,
	input wire logic low_we,
	input wire logic [7:0] low_wdata,
	input wire logic jump_en,
	input wire logic [JUMP_W-1:0] jump_target,
	input wire logic [HOLD_W-1:0] holding,
	// counter value
	output logic [PC_W-1:0] pc
);

	logic [PC_W-1:0] next_pc; // value for the coming edge

	// ==========================================================
	// next counter: a low-byte write beats a jump beats a step
	// ==========================================================
	always_comb begin
		next_pc = pc;
		if (sys_rst) begin
			next_pc = '0;
		end else if (low_we) begin
			// upper bits come only from the holding register
			next_pc = {holding, low_wdata};
		end else if (jump_en) begin
			next_pc = {holding[HOLD_W-1:HOLD_W-2], jump_target};
		end else if (pc_step) begin
			next_pc = pc + 13'h0001;
		end
	end

	// register only
	always_ff @(posedge clk) begin
		pc <= next_pc;
	end

endmodule

// ==== logic/sbm_map_top.sv ====
// Contract
// - unmapped locations read zero, ignore writes
// - shared core registers mirror in both banks
// - upper counter loaded from holding register; a jump loads only bits 12:11 from it
// - power-up resets differ from other resets
`timescale 1ns/100ps
module sbm_map_top
	import sbm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rst_por,
	input wire logic [1:0] rst_to_pd,
	// register port from the core
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	// data memory port
	output logic [ADDR_W-1:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	output logic dmem_we,
	output logic dmem_re,
	input wire logic [7:0] dmem_rdata,
	// program counter
	input wire logic pc_step,
	input wire logic jump_en,
	input wire logic [JUMP_W-1:0] jump_target,
	output logic [PC_W-1:0] pc,
	// interrupt flag events
	input wire logic [INTERRUPT_CONTROL_FLAGS-1:0] interrupt_control_set,
	input wire logic [7:0] peripheral_irq_flags_set,
	output logic [7:0] interrupt_control,
	output logic [7:0] peripheral_irq_flags,
	output logic [7:0] core_status,
	// plain registers and port pins
	output logic [NREG*8-1:0] sfr_q,
	input wire logic [NPORT*8-1:0] port_pins
);

	// ==========================================================
	// decode
	// ==========================================================
	logic [7:0] reg_q [NREG]; // plain register values
	logic [ADDR_W-1:0] eff_addr; // address after indirection
	logic is_indirect; // access names the indirect location
	logic in_sfr; // effective address inside the special window
	logic bank_ok; // bank 0, or a register shared by both banks
	logic sfr_ok; // an access that this map may answer
	logic to_dmem; // access that goes to data memory
	logic [NREG-1:0] hit; // plain register selected
	logic hit_pcl; // program counter low selected
	logic hit_status; // core status selected
	logic hit_interrupt_control; // interrupt control selected
	logic hit_peripheral_irq_flags; // peripheral flags selected
	logic acc; // either strobe
	logic [7:0] next_rd_q; // sfr read value for the next cycle
	logic [7:0] rd_sfr; // registered sfr read value
	logic next_rd_dmem; // next cycle answers from memory
	logic rd_dmem; // this cycle answers from memory

	// shared core registers respond in both banks
	function automatic logic is_shared(input logic [6:0] off);
		is_shared = (off == OFF_INDIRECT) || (off == OFF_PCL) || (off == OFF_STATUS) ||
			(off == OFF_POINTER) || (off == OFF_HOLDING) || (off == OFF_INTERRUPT_CONTROL);
	endfunction

	assign acc = wr_stb | rd_stb;

	// the indirect location swaps in the pointer as the address
	always_comb begin
		is_indirect = (addr[6:0] == OFF_INDIRECT);
		eff_addr = is_indirect ? reg_q[IDX_POINTER] : addr;
		in_sfr = (eff_addr[6:0] < SFR_SPAN);
		bank_ok = !eff_addr[BANK_BIT] || is_shared(eff_addr[6:0]);
		// an indirect pointing at the indirect location reaches nothing
		sfr_ok = in_sfr && bank_ok && (eff_addr[6:0] != OFF_INDIRECT);
		to_dmem = acc && !in_sfr;
		hit_pcl = sfr_ok && (eff_addr[6:0] == OFF_PCL);
		hit_status = sfr_ok && (eff_addr[6:0] == OFF_STATUS);
		hit_interrupt_control = sfr_ok && (eff_addr[6:0] == OFF_INTERRUPT_CONTROL);
		hit_peripheral_irq_flags = sfr_ok && (eff_addr[6:0] == OFF_PERIPHERAL_IRQ_FLAGS);
		for (int i = 0; i < NREG; i++) begin
			hit[i] = sfr_ok && (eff_addr[6:0] == REG_OFF[i]);
		end
	end

	// memory port sees the pointer address the same cycle
	assign dmem_addr = eff_addr;
	assign dmem_wdata = wdata;
	assign dmem_we = wr_stb && to_dmem;
	assign dmem_re = rd_stb && to_dmem;

	// ==========================================================
	// plain registers, one instance each
	// ==========================================================
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			sbm_reg #(
				.MASK(REG_MASK[gi]),
				.POR_VAL(REG_POR[gi]),
				.OTHER_VAL(REG_OTHER[gi]),
				.KEEP(REG_KEEP[gi])
			) u_reg (
				.clk(clk),
				.sys_rst(sys_rst),
				.rst_por(rst_por),
				.we(wr_stb && hit[gi]),
				.wdata(wdata),
				.q(reg_q[gi])
			);
			assign sfr_q[gi*8 +: 8] = reg_q[gi];
		end
	endgenerate

	// ==========================================================
	// program counter; upper bits hidden behind the holding register
	// ==========================================================
	sbm_pc u_pc (
		.clk(clk),
		.sys_rst(sys_rst),
		.pc_step(pc_step),
		.low_we(wr_stb && hit_pcl),
		.low_wdata(wdata),
		.jump_en(jump_en),
		.jump_target(jump_target),
		.holding(reg_q[IDX_HOLDING][HOLD_W-1:0]),
		.pc(pc)
	);

	// ==========================================================
	// status, interrupt control and peripheral flags
	// ==========================================================
	logic [7:0] next_status; // status for the coming edge
	logic [7:0] next_interrupt_control; // interrupt control for the coming edge
	logic [7:0] next_peripheral_irq_flags; // peripheral flags for the coming edge

	// flags set by hardware win over a software clear in the same cycle
	always_comb begin
		next_status = core_status;
		next_interrupt_control = interrupt_control;
		next_peripheral_irq_flags = peripheral_irq_flags;
		if (sys_rst) begin
			if (rst_por) begin
				next_status = STATUS_POR;
				next_interrupt_control = INTERRUPT_CONTROL_RST;
			end else begin
				// timeout and power-down tell the cause of the reset
				next_status = (core_status & STATUS_KEEP) |
					{3'h0, rst_to_pd, 3'h0};
				next_interrupt_control = (interrupt_control & INTERRUPT_CONTROL_KEEP) |
					(INTERRUPT_CONTROL_RST & ~INTERRUPT_CONTROL_KEEP);
			end
			next_peripheral_irq_flags = PERIPHERAL_IRQ_FLAGS_RST;
		end else begin
			if (wr_stb && hit_status) begin
				// reserved bank bits are stored as written; software keeps them clear
				next_status = (wdata & STATUS_WR_MASK) | (core_status & ~STATUS_WR_MASK);
			end
			if (wr_stb && hit_interrupt_control) begin
				next_interrupt_control = wdata;
			end
			if (wr_stb && hit_peripheral_irq_flags) begin
				next_peripheral_irq_flags = wdata & PERIPHERAL_IRQ_FLAGS_IMPL;
			end
			next_interrupt_control[INTERRUPT_CONTROL_FLAGS-1:0] = next_interrupt_control[INTERRUPT_CONTROL_FLAGS-1:0] | interrupt_control_set;
			next_peripheral_irq_flags = next_peripheral_irq_flags | (peripheral_irq_flags_set & PERIPHERAL_IRQ_FLAGS_IMPL);
		end
	end

	// register only
	always_ff @(posedge clk) begin
		core_status <= next_status;
		interrupt_control <= next_interrupt_control;
		peripheral_irq_flags <= next_peripheral_irq_flags;
	end

	// ==========================================================
	// read path: answer in the cycle after the strobe
	// ==========================================================
	always_comb begin
		next_rd_q = 8'h00; // unmapped and empty locations read zero
		next_rd_dmem = rd_stb && to_dmem;
		if (rd_stb && sfr_ok) begin
			if (hit_pcl) begin
				next_rd_q = pc[7:0];
			end else if (hit_status) begin
				next_rd_q = core_status;
			end else if (hit_interrupt_control) begin
				next_rd_q = interrupt_control;
			end else if (hit_peripheral_irq_flags) begin
				next_rd_q = peripheral_irq_flags;
			end
			for (int i = 0; i < NREG; i++) begin
				if (hit[i]) begin
					// ports return pin levels, other registers their latch
					// non-port entries point at port 0 so the slice stays in range
					next_rd_q = REG_PIN[i] ?
						(port_pins[((i >= IDX_PORT0) ? (i - IDX_PORT0) : 0)*8 +: 8] &
						REG_MASK[i]) : reg_q[i];
				end
			end
		end
		if (sys_rst) begin
			next_rd_q = 8'h00;
			next_rd_dmem = 1'b0;
		end
	end

	// register only
	always_ff @(posedge clk) begin
		rd_sfr <= next_rd_q;
		rd_dmem <= next_rd_dmem;
	end

	// memory data is already registered by the memory itself
	assign rd_data = rd_dmem ? dmem_rdata : rd_sfr;

	// ==========================================================
	// checks
	// ==========================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic unmapped_acc; // access at a bank 0 location with no register
	assign unmapped_acc = !addr[BANK_BIT] && ((addr[6:0] == 7'h0d) ||
		((addr[6:0] >= 7'h18) && (addr[6:0] < SFR_SPAN)));

	AST_UNMAPPED_READ_ZERO: assert property (
		rd_stb && unmapped_acc |=> rd_data == 8'h00)
		else $error("unmapped location did not read zero");
	AST_UNMAPPED_WRITE_NONE: assert property (
		wr_stb && unmapped_acc && !pc_step && !jump_en |=> $stable(sfr_q) && $stable(pc) &&
		$stable(core_status))
		else $error("write to unmapped location changed state");
	AST_SHARED_POINTER: assert property (
		wr_stb && addr == 8'h84 |=> reg_q[IDX_POINTER] == $past(wdata))
		else $error("pointer not reached from bank 1");
	AST_SHARED_HOLDING_READ: assert property (
		rd_stb && addr == 8'h8a |=> rd_data == {3'h0, reg_q[IDX_HOLDING][4:0]})
		else $error("holding register not mirrored in bank 1");
	AST_PCL_LOADS_UPPER: assert property (
		wr_stb && addr[6:0] == OFF_PCL |=>
		pc == {$past(reg_q[IDX_HOLDING][4:0]), $past(wdata)})
		else $error("counter not loaded from holding register");
	AST_HOLDING_NOT_PC: assert property (
		wr_stb && addr[6:0] == OFF_HOLDING && !pc_step && !jump_en |=> $stable(pc))
		else $error("holding write moved the counter");
	AST_POR_STATUS: assert property (@(posedge clk) disable iff (1'b0)
		sys_rst && rst_por |=> core_status == STATUS_POR && pc == 13'h0000)
		else $error("power-up reset value wrong");
	AST_OTHER_RESET_KEEPS: assert property (@(posedge clk) disable iff (1'b0)
		sys_rst && !rst_por |=> reg_q[IDX_POINTER] == $past(reg_q[IDX_POINTER]) &&
		core_status[2:0] == $past(core_status[2:0]) &&
		core_status[4:3] == $past(rst_to_pd))
		else $error("other reset lost unchanged bits");
	AST_INDIRECT_WRITE: assert property (
		wr_stb && is_indirect && reg_q[IDX_POINTER][6:0] >= SFR_SPAN |->
		dmem_we && dmem_addr == reg_q[IDX_POINTER] && dmem_wdata == wdata)
		else $error("indirect write did not reach memory");
	AST_INDIRECT_READ: assert property (
		rd_stb && is_indirect && reg_q[IDX_POINTER][6:0] >= SFR_SPAN |->
		dmem_re ##1 rd_data == dmem_rdata)
		else $error("indirect read did not return memory data");
	AST_FLAG_SET_WINS: assert property (
		peripheral_irq_flags_set[0] && wr_stb && addr[6:0] == OFF_PERIPHERAL_IRQ_FLAGS && !addr[BANK_BIT] |=>
		peripheral_irq_flags[0])
		else $error("flag event lost against clear");

	// further guards on gaps, banking, jumps and reset values
	AST_PERIPHERAL_IRQ_FLAGS_GAP_ZERO: assert property (
		peripheral_irq_flags[5:4] == 2'b00)
		else $error("unimplemented flag bits set");
	AST_BANK1_PLAIN_ZERO: assert property (
		rd_stb && addr == 8'h81 |=> rd_data == 8'h00)
		else $error("bank 1 copy of a bank 0 register answered");
	AST_SHARED_STATUS_WRITE: assert property (
		wr_stb && addr[6:0] == OFF_STATUS |=>
		(core_status & STATUS_WR_MASK) == ($past(wdata) & STATUS_WR_MASK))
		else $error("status write not taken");
	AST_STATUS_CAUSE_HELD: assert property (
		wr_stb && addr[6:0] == OFF_STATUS |=> core_status[4:3] == $past(core_status[4:3]))
		else $error("status write changed the reset cause bits");
	AST_JUMP_UPPER: assert property (
		jump_en && !(wr_stb && hit_pcl) |=> pc[12:11] == $past(reg_q[IDX_HOLDING][4:3]))
		else $error("jump did not take upper bits from holding register");
	AST_POR_CLEARS_REGS: assert property (@(posedge clk) disable iff (1'b0)
		sys_rst && rst_por |=> sfr_q == '0 && peripheral_irq_flags == 8'h00)
		else $error("power-up reset left a register set");

	COV_INDIRECT_READ: cover property (rd_stb && is_indirect ##1 rd_dmem);
	COV_PCL_WRITE: cover property (wr_stb && hit_pcl ##1 pc[12:8] != 5'h00);
	COV_OTHER_RESET: cover property (@(posedge clk) disable iff (1'b0)
		sys_rst && !rst_por ##1 !sys_rst);
	COV_FLAG_RACE: cover property (peripheral_irq_flags_set != 8'h00 && wr_stb && hit_peripheral_irq_flags);

endmodule

// ==== tb/sbm_tb.sv ====
`timescale 1ns/100ps
module testbench
	import sbm_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	// ==========================================================
	logic clk = 1'b0; // 125 MHz core clock
	logic sys_rst = 1'b1;
	logic rst_por = 1'b1; // power-up cause during the first reset
	logic [1:0] rst_to_pd = 2'b00;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rd_data;
	logic [ADDR_W-1:0] dmem_addr;
	logic [7:0] dmem_wdata;
	logic dmem_we;
	logic dmem_re;
	logic [7:0] dmem_rdata = 8'h00;
	logic pc_step = 1'b0;
	logic jump_en = 1'b0;
	logic [JUMP_W-1:0] jump_target = 11'h000;
	logic [PC_W-1:0] pc;
	logic [INTERRUPT_CONTROL_FLAGS-1:0] interrupt_control_set = 3'h0;
	logic [7:0] peripheral_irq_flags_set = 8'h00;
	logic [7:0] interrupt_control;
	logic [7:0] peripheral_irq_flags;
	logic [7:0] core_status;
	logic [NREG*8-1:0] sfr_q;
	logic [NPORT*8-1:0] port_pins = {5{8'hff}}; // all pins high shows the masked bits
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] q; // last read answer
	logic s; // memory strobe seen in the access cycle
	logic [7:0] ma; // memory address seen in the access cycle
	logic [7:0] unmapped [11] = '{8'h0d, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
		8'h1f, 8'h8d, 8'h81};

	always #4 clk = ~clk;

	sbm_map_top uut (.clk(clk), .sys_rst(sys_rst), .rst_por(rst_por), .rst_to_pd(rst_to_pd),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
		.dmem_rdata(dmem_rdata), .pc_step(pc_step), .jump_en(jump_en),
		.jump_target(jump_target), .pc(pc), .interrupt_control_set(interrupt_control_set), .peripheral_irq_flags_set(peripheral_irq_flags_set),
		.interrupt_control(interrupt_control), .peripheral_irq_flags(peripheral_irq_flags),
		.core_status(core_status), .sfr_q(sfr_q), .port_pins(port_pins));

	// ==========================================================
	// verdict and hang guard
	// ==========================================================
	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// whole run is under two hundred cycles; this bound only catches a stuck sequence
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			n_mismatch = n_mismatch + 1;
			finish_test();
		end
	end

	// ==========================================================
	// bus tasks
	// ==========================================================
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one strobe cycle; memory answers only in the cycle after, otherwise shows noise
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] m);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= w;
		rd_stb <= !w;
		#1 s = w ? dmem_we : dmem_re;
		ma = dmem_addr;
		@(posedge clk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		dmem_rdata <= m;
		#1 q = rd_data;
		@(posedge clk);
		dmem_rdata <= ~m;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 8'h00);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00, 8'h00);
		cmp(q, exp);
	endtask

	task automatic do_rst(input logic por, input logic [1:0] tp);
		@(posedge clk);
		sys_rst <= 1'b1;
		rst_por <= por;
		rst_to_pd <= tp;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
	endtask

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		// power-up values
		rd_chk(8'h03, STATUS_POR);
		rd_chk(8'h0a, 8'h00);
		rd_chk(8'h0c, 8'h00);
		// unmapped places swallow writes and read zero, never reach memory
		foreach (unmapped[i]) begin
			wr(unmapped[i], 8'hff);
			cmp(s, 1'b0);
			rd_chk(unmapped[i], 8'h00);
		end
		// unimplemented bits of ports and flags read zero
		rd_chk(8'h05, 8'h3f);
		rd_chk(8'h09, 8'h07);
		@(posedge clk) peripheral_irq_flags_set <= 8'hff;
		@(posedge clk) peripheral_irq_flags_set <= 8'h00;
		#1 cmp(peripheral_irq_flags, 8'hcf);
		// a hardware set in the same cycle as a clearing write wins; bit 0 set by hardware, the rest written clear
		@(posedge clk);
		addr <= 8'h0c;
		wdata <= 8'h00;
		wr_stb <= 1'b1;
		peripheral_irq_flags_set <= 8'h01;
		@(posedge clk);
		wr_stb <= 1'b0;
		peripheral_irq_flags_set <= 8'h00;
		#1 cmp(peripheral_irq_flags, 8'h01);
		// shared core registers written in one bank, read in the other
		wr(8'h84, 8'h40);
		rd_chk(8'h04, 8'h40);
		wr(8'h03, 8'h25); // bank selects above bit 5 kept clear
		rd_chk(8'h83, 8'h3d);
		wr(8'h8a, 8'h12);
		rd_chk(8'h0a, 8'h12);
		@(posedge clk) interrupt_control_set <= 3'h7;
		@(posedge clk) interrupt_control_set <= 3'h0;
		rd_chk(8'h8b, 8'h07);
		wr(8'h0b, 8'h81);
		rd_chk(8'h8b, 8'h81);
		// counter low write pulls the upper bits from the holding register
		wr(8'h02, 8'h34);
		cmp(pc, 16'h1234);
		rd_chk(8'h82, 8'h34);
		wr(8'h0a, 8'h1f);
		@(posedge clk);
		jump_en <= 1'b1;
		jump_target <= 11'h123;
		@(posedge clk);
		jump_en <= 1'b0;
		pc_step <= 1'b1;
		#1 cmp(pc, 16'h1923);
		@(posedge clk) pc_step <= 1'b0;
		#1 cmp(pc, 16'h1924);
		// indirect location goes to memory at the pointer, holds nothing itself
		acc(1'b0, 8'h00, 8'h00, 8'ha5);
		cmp(s, 1'b1);
		cmp(ma, 8'h40);
		cmp(q, 8'ha5);
		acc(1'b1, 8'h80, 8'h5a, 8'h00);
		cmp(s, 1'b1);
		cmp(ma, 8'h40);
		cmp(dmem_wdata, 8'h5a);
		wr(8'h04, 8'h00);
		acc(1'b0, 8'h00, 8'h00, 8'h77);
		cmp(s, 1'b0);
		cmp(q, 8'h00);
		// other reset keeps marked bits, loads timeout and power-down from the cause
		wr(8'h01, 8'h77);
		do_rst(1'b0, 2'b01);
		rd_chk(8'h01, 8'h77);
		rd_chk(8'h03, 8'h0d);
		rd_chk(8'h0a, 8'h00);
		rd_chk(8'h0b, 8'h01);
		cmp(pc, 16'h0000);
		cmp(sfr_q[7:0], 8'h77);
		cmp(core_status, 8'h0d);
		cmp(interrupt_control, 8'h01);
		// the brown-out flag lives outside this bank, so nothing here to keep set
		do_rst(1'b1, 2'b00);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h03, STATUS_POR);
		rd_chk(8'h0b, 8'h00);
		finish_test();
	end
endmodule
